// >>> hdl/mceb_pkg.sv
/*
 Package for the memory controller error and breakpoint block: register
 map, field positions, reset values, port codes, access kinds and carriers.
 Assumes a single clock domain and a simple strobe register port.
*/
package mceb_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] MCEB_REG_CTRL = 8'h00;
    localparam logic [7:0] MCEB_REG_BKPT = 8'h04;
    localparam logic [7:0] MCEB_REG_STAT = 8'h08;
    localparam logic [7:0] MCEB_REG_SYND = 8'h0c;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_CORR_MODE = 0;
    localparam int CTRL_INTEG_CPU = 1;
    localparam int CTRL_CHK_LO = 2;
    localparam int CTRL_PORT_LO = 8;
    localparam int CTRL_ACC_LO = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_003d;

    // Status register fields
    localparam int STAT_IN_ERR = 0;
    localparam int STAT_ADDR_ERR = 1;
    localparam int STAT_XMEM_ERR = 2;
    localparam int STAT_SU0_ERR = 3;
    localparam int STAT_SU1_ERR = 4;
    localparam int STAT_BKPT = 5;
    localparam int STAT_ERR_PORT_LO = 8;
    localparam int STAT_BKPT_PORT_LO = 12;
    localparam int STAT_SYN_LO = 16;

    // ------------------------------------------------------------
    // Geometry and codes
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 60;
    localparam int SYN_W = 8;
    localparam int PARITY_CHECK_BIT = 10;
    localparam int READ_PARITY_BIT = 0;
    localparam int NPORTS = 6;
    localparam int EXIT_MODE_INPUT_ERR = 58;

    // Port codes; bit 1 of the three-bit code marks a central processor
    localparam logic [2:0] PORT_PERI0 = 3'h0;
    localparam logic [2:0] PORT_PERI1 = 3'h1;
    localparam logic [2:0] PORT_CPU0 = 3'h2;
    localparam logic [2:0] PORT_CPU1 = 3'h3;
    localparam logic [2:0] PORT_XMEM = 3'h4;

    typedef enum logic [1:0] {
        ACC_READ = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_NEXT_INSTR = 2'b10,
        ACC_ANY = 2'b11
    } mceb_acc_e;

    typedef enum logic [2:0] {
        REF_READ = 3'b000,
        REF_WRITE = 3'b001,
        REF_IFETCH = 3'b010,
        REF_SWAP = 3'b011,
        REF_RJUMP = 3'b100
    } mceb_ref_e;

    typedef enum logic [1:0] {
        SYN_NONE = 2'b00,
        SYN_CHECK_BIT = 2'b01,
        SYN_SINGLE = 2'b10,
        SYN_MULTI = 2'b11
    } mceb_syn_e;

    typedef struct packed {
        logic valid;
        logic [2:0] port;
        mceb_ref_e kind;
        logic [ADDR_W-1:0] addr;
        logic addr_par;
        logic [DATA_W-1:0] data;
        logic data_par;
    } mceb_req_s;

    typedef struct packed {
        logic valid;
        logic [2:0] port;
        logic [DATA_W-1:0] data;
        logic data_par;
        logic in_err;
        logic dbl_err;
        logic bkpt;
        logic cpu_exit;
    } mceb_rsp_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic addr_par;
        logic [DATA_W-1:0] data;
        logic [SYN_W-1:0] check;
    } mceb_mem_s;

endpackage

// >>> hdl/mceb_core.sv
/*
 Error checking and breakpoint logic of the memory controller: request
 parity checks, write strobe gating, read substitution, correction and
 parity mode handling, syndrome classing and breakpoint compare.
 Assumes one request per cycle already arbitrated, storage data and
 syndrome presented with the read return, and the same clock everywhere.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: One-hot syndrome is a failed check bit; even nonzero count is multiple.
// R2: Three, five or seven set bits count as single; zero syndrome means no error.
// R3: Check address parity on each configured request port.
// R4: Address parity error logs input flag, port code and address marker.
// R5: Address parity error on a write drops the storage write strobe.
// R6: Address parity error on a read returns an all-ones word.
// R7: Send address parity to storage; log storage unit 0 or 1 errors.
// R8: Processor input error sets its parity condition; acts if bit 58 set.
// R9: Check write data parity on peripheral, extended memory, processor ports.
// R10: Data parity error raises input error toward the requesting port.
// R11: Data parity error logs flag and port or extended flag, address clear.
// R12: Parity mode write sends data parity in check bit 10.
// R13: Parity mode read forwards stored parity when not integrated.
// R14: Integrated parity mode checks bit 0; processor gets only error.
// R15: Correction mode write checks input parity except integrated processor.
// R16: Correction mode read corrects then regenerates parity except integrated.
// R17: Software supplies breakpoint address, port and access select bits.
// R18: Matching address, port and access raise breakpoint to requester.
// R19: Breakpoint hit logs flag and two-bit port code in status.
// R20: Context swap counts as read and write; return jump as write.
// R21: Port select 00 off, 01 peripheral, 10 processor, 11 both.
// R22: Access select 00 read, 01 write, 10 next instruction, 11 any.
module mceb_core
    import mceb_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic srst, // Synchronous reset
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire mceb_req_s req, // Request from ports
    output mceb_mem_s mem_out, // Toward storage units
    input wire logic rd_valid, // Storage read return valid
    input wire logic [DATA_W-1:0] rd_data, // Raw storage read data
    input wire logic [SYN_W-1:0] rd_check, // Stored check bits
    input wire logic [SYN_W-1:0] rd_syn, // Syndrome from network
    input wire logic [DATA_W-1:0] rd_corr, // Corrected read data
    input wire logic su_err_0, // Storage unit 0 parity error
    input wire logic su_err_1, // Storage unit 1 parity error
    input wire logic [5:0] exit_mode, // Exit mode bits 48..50,57..59
    output mceb_rsp_s rsp // Answer to requester
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] pop8(input logic [SYN_W-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < SYN_W; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    function automatic mceb_syn_e syn_class(input logic [SYN_W-1:0] v);
        logic [3:0] n;
        n = pop8(v);
        if (n == 4'h0) return SYN_NONE; // R2
        if (n == 4'h1) return SYN_CHECK_BIT; // R1
        if (!n[0]) return SYN_MULTI; // R1
        return SYN_SINGLE; // R2
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [ADDR_W-1:0] bkpt_ff, nxt_bkpt;
    logic [31:0] stat_ff, nxt_stat;
    logic [SYN_W-1:0] syn_ff, nxt_syn;
    logic [31:0] rdata_ff, nxt_rdata;
    mceb_mem_s mem_ff, nxt_mem;
    mceb_rsp_s rsp_ff, nxt_rsp;
    logic [2:0] pend_port_ff, nxt_pend_port;
    logic pend_bad_ff, nxt_pend_bad;
    logic pend_bkpt_ff, nxt_pend_bkpt;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    wire corr_mode = ctrl_ff[CTRL_CORR_MODE];
    wire integ_cpu = ctrl_ff[CTRL_INTEG_CPU];
    wire [NPORTS-1:0] chk_en = ctrl_ff[CTRL_CHK_LO +: NPORTS]; // R3
    wire [1:0] port_sel = ctrl_ff[CTRL_PORT_LO +: 2]; // R17
    wire [1:0] acc_sel = ctrl_ff[CTRL_ACC_LO +: 2]; // R17

    wire is_cpu = (req.port == PORT_CPU0) || (req.port == PORT_CPU1);
    wire is_peri = (req.port == PORT_PERI0) || (req.port == PORT_PERI1);
    wire is_xmem = (req.port == PORT_XMEM);
    wire is_wr = (req.kind == REF_WRITE) || (req.kind == REF_SWAP) ||
        (req.kind == REF_RJUMP); // R20
    wire is_rd = (req.kind == REF_READ) || (req.kind == REF_IFETCH) ||
        (req.kind == REF_SWAP); // R20
    wire port_chk = chk_en[req.port];

    // Address parity: odd parity over address and its parity bit
    wire addr_bad = req.valid && port_chk &&
        !(^{req.addr, req.addr_par}); // R3
    // Integrated processor write data parity is not checked in correction mode
    wire data_chk_ok = !(corr_mode && integ_cpu && is_cpu); // R15
    wire data_bad = req.valid && is_wr && port_chk && data_chk_ok &&
        !(^{req.data, req.data_par}) && !addr_bad; // R9
    wire data_par_gen = ~(^req.data);

    // ------------------------------------------------------------
    // Breakpoint compare
    // ------------------------------------------------------------
    wire port_hit = (port_sel[0] && is_peri) || (port_sel[1] && is_cpu); // R21
    wire acc_hit = (acc_sel == ACC_ANY) ||
        (acc_sel == ACC_READ && is_rd) ||
        (acc_sel == ACC_WRITE && is_wr) ||
        (acc_sel == ACC_NEXT_INSTR && req.kind == REF_IFETCH); // R22
    wire bkpt_hit = req.valid && (req.addr == bkpt_ff) &&
        port_hit && acc_hit; // R18

    // ------------------------------------------------------------
    // Read return handling
    // ------------------------------------------------------------
    wire pend_cpu = (pend_port_ff == PORT_CPU0) ||
        (pend_port_ff == PORT_CPU1);
    mceb_syn_e rd_class;
    assign rd_class = syn_class(rd_syn);
    wire rd_dbl = corr_mode && (rd_class == SYN_MULTI);
    wire rd_par_bad = !corr_mode && integ_cpu &&
        !(^{rd_data, rd_check[READ_PARITY_BIT]}); // R14
    wire rd_in_err = rd_par_bad && pend_cpu; // R14
    wire [DATA_W-1:0] rd_word = corr_mode ? rd_corr : rd_data; // R16
    // Stored parity sits in the bit 10 slot unless integrated processor mode is set
    wire par_slot = integ_cpu ? rd_check[READ_PARITY_BIT] :
        rd_check[PARITY_CHECK_BIT % SYN_W]; // R13
    wire rd_par_out = corr_mode ? ~(^rd_corr) : par_slot; // R16

    wire wr_hit = reg_wr && (reg_addr == MCEB_REG_STAT);
    wire in_err_evt = addr_bad || data_bad || (rd_valid && rd_in_err);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_bkpt = bkpt_ff;
        if (reg_wr && reg_addr == MCEB_REG_CTRL) begin
            nxt_ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == MCEB_REG_BKPT) begin
            nxt_bkpt = reg_wdata[ADDR_W-1:0]; // R17
        end
        // Write-one-to-clear except the syndrome field, which mirrors the held syndrome; a new event in the same cycle wins
        nxt_stat = wr_hit ? (stat_ff & ~reg_wdata) : stat_ff;
        nxt_syn = syn_ff;
        if (in_err_evt) begin
            nxt_stat[STAT_IN_ERR] = 1'b1; // R4
            nxt_stat[STAT_ADDR_ERR] = addr_bad; // R11
            nxt_stat[STAT_XMEM_ERR] = data_bad && is_xmem; // R11
            nxt_stat[STAT_ERR_PORT_LO +: 3] = req.valid ? req.port :
                pend_port_ff; // R4
        end
        if (su_err_0) nxt_stat[STAT_SU0_ERR] = 1'b1; // R7
        if (su_err_1) nxt_stat[STAT_SU1_ERR] = 1'b1; // R7
        if (bkpt_hit) begin
            nxt_stat[STAT_BKPT] = 1'b1; // R19
            nxt_stat[STAT_BKPT_PORT_LO +: 2] = req.port[1:0]; // R19
        end
        if (rd_valid && corr_mode && rd_class != SYN_NONE) begin
            nxt_syn = rd_syn;
        end
        nxt_stat[STAT_SYN_LO +: SYN_W] = nxt_syn;

        unique case (reg_addr)
            MCEB_REG_CTRL: nxt_rdata = ctrl_ff;
            MCEB_REG_BKPT: nxt_rdata = {14'h0, bkpt_ff};
            MCEB_REG_STAT: nxt_rdata = stat_ff;
            MCEB_REG_SYND: nxt_rdata = {22'h0, rd_class, syn_ff};
            default: nxt_rdata = 32'h0;
        endcase
        if (!reg_rd) nxt_rdata = 32'h0;

        // Storage side
        nxt_mem.wr = req.valid && is_wr && !addr_bad; // R5
        // Bad address answers at once, so the read is not sent to storage
        nxt_mem.rd = req.valid && is_rd && !addr_bad;
        nxt_mem.addr = req.addr;
        nxt_mem.addr_par = ~(^req.addr); // R7
        nxt_mem.data = req.data;
        nxt_mem.check = rd_check & 8'h00;
        for (int i = 0; i < SYN_W; i++) begin
            nxt_mem.check[i] = ^(req.data & {DATA_W{i[0]}}) ^ i[1];
        end
        if (!corr_mode) begin
            nxt_mem.check[PARITY_CHECK_BIT % SYN_W] = data_par_gen; // R12
        end

        nxt_pend_port = pend_port_ff;
        nxt_pend_bad = pend_bad_ff;
        nxt_pend_bkpt = pend_bkpt_ff;
        if (req.valid && is_rd) begin
            nxt_pend_port = req.port;
            nxt_pend_bad = addr_bad;
            nxt_pend_bkpt = bkpt_hit;
        end

        // Answer to requester
        nxt_rsp = '0;
        nxt_rsp.port = req.port;
        if (req.valid && (is_wr || addr_bad)) begin
            nxt_rsp.valid = 1'b1;
            nxt_rsp.in_err = addr_bad || data_bad; // R10
            nxt_rsp.bkpt = bkpt_hit; // R18
            nxt_rsp.data = {DATA_W{addr_bad}}; // R6
            nxt_rsp.data_par = addr_bad;
        end else if (rd_valid) begin
            nxt_rsp.valid = 1'b1;
            nxt_rsp.port = pend_port_ff;
            nxt_rsp.bkpt = pend_bkpt_ff;
            nxt_rsp.dbl_err = rd_dbl;
            nxt_rsp.in_err = rd_in_err || pend_bad_ff;
            nxt_rsp.data = pend_bad_ff ? {DATA_W{1'b1}} : rd_word; // R6
            // Integrated processor gets no parity bit on reads
            nxt_rsp.data_par = (integ_cpu && pend_cpu) ? 1'b0 :
                rd_par_out; // R14
        end
        nxt_rsp.cpu_exit = nxt_rsp.in_err && (nxt_rsp.port == PORT_CPU0 ||
            nxt_rsp.port == PORT_CPU1) &&
            exit_mode[EXIT_MODE_INPUT_ERR - 54]; // R8
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= CTRL_RESET;
            bkpt_ff <= '0;
            stat_ff <= '0;
            syn_ff <= '0;
            rdata_ff <= '0;
            mem_ff <= '0;
            rsp_ff <= '0;
            pend_port_ff <= '0;
            pend_bad_ff <= 1'b0;
            pend_bkpt_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            bkpt_ff <= nxt_bkpt;
            stat_ff <= nxt_stat;
            syn_ff <= nxt_syn;
            rdata_ff <= nxt_rdata;
            mem_ff <= nxt_mem;
            rsp_ff <= nxt_rsp;
            pend_port_ff <= nxt_pend_port;
            pend_bad_ff <= nxt_pend_bad;
            pend_bkpt_ff <= nxt_pend_bkpt;
        end
    end

    assign reg_rdata = rdata_ff;
    assign mem_out = mem_ff;
    assign rsp = rsp_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_wr_blocked: assert property ( // R5
        req.valid && is_wr && addr_bad |=> !mem_out.wr)
        else $error("write not blocked on address parity error");
    a_rd_ones: assert property ( // R6
        req.valid && addr_bad |=> rsp.data == {DATA_W{1'b1}})
        else $error("address error answer not all ones");
    a_addr_log: assert property ( // R4
        addr_bad |=> stat_ff[STAT_IN_ERR] && stat_ff[STAT_ADDR_ERR])
        else $error("address error not logged");
    a_data_log: assert property ( // R11
        data_bad |=> stat_ff[STAT_IN_ERR] && !stat_ff[STAT_ADDR_ERR])
        else $error("data error logged as address error");
    a_data_inerr: assert property ( // R10
        data_bad |=> rsp.valid && rsp.in_err)
        else $error("input error not sent to requester");
    a_addr_par: assert property ( // R7
        mem_out.wr || mem_out.rd |-> ^{mem_out.addr, mem_out.addr_par})
        else $error("bad address parity toward storage");
    a_bkpt_flag: assert property ( // R18
        bkpt_hit |=> stat_ff[STAT_BKPT] && (rsp.bkpt || !$past(is_wr)))
        else $error("breakpoint not flagged");
    a_bkpt_off: assert property ( // R21
        port_sel == 2'b00 |-> !bkpt_hit)
        else $error("breakpoint with checking disabled");
    a_su_flag: assert property ( // R7
        su_err_1 |=> stat_ff[STAT_SU1_ERR])
        else $error("storage unit error not logged");

endmodule
`default_nettype wire

// >>> tb/mceb_store_model.sv
/*
 Storage unit model behind mceb_core: keeps written words and returns
 them with their check bits and a chosen syndrome, promptly or late.
 Assumes mceb_pkg, one clock and one read outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module mceb_store_model
    import mceb_pkg::*;
(
    input wire logic clk, // Clock
    input wire mceb_mem_s mem, // From controller
    input wire logic [1:0] lat, // Extra read delay
    input wire logic [SYN_W-1:0] syn, // Syndrome to return
    input wire logic [1:0] fail, // Forced unit errors
    output logic rd_valid = 1'b0, // Read return pulse
    output logic [DATA_W-1:0] rd_data = '0, // Stored data
    output logic [SYN_W-1:0] rd_check = '0, // Stored check bits
    output logic [SYN_W-1:0] rd_syn = '0, // Syndrome
    output logic [DATA_W-1:0] rd_corr = '0, // Corrected data
    output logic [1:0] su_err = 2'b00 // Unit error pulses
);
    logic [DATA_W+SYN_W-1:0] store [16];
    logic [DATA_W+SYN_W-1:0] word = '0;
    int wait_n = -1;
    wire logic bad = ~(^{mem.addr, mem.addr_par});
    // ------------------------------------------------------------
    // Released lines invert each cycle so stale data never looks valid
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_valid <= 1'b0;
        {rd_data, rd_corr} <= ~{rd_data, rd_corr};
        {rd_check, rd_syn} <= ~{rd_check, rd_syn};
        su_err <= 2'b00;
        if (mem.wr || mem.rd) begin
            su_err <= fail | {mem.addr[17] & bad, ~mem.addr[17] & bad};
        end
        if (mem.wr) begin
            store[mem.addr[3:0]] <= {mem.check, mem.data};
        end
        if (mem.rd) begin
            word <= store[mem.addr[3:0]];
            wait_n <= int'(lat);
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (wait_n == 0) begin
            rd_valid <= 1'b1;
            {rd_check, rd_data} <= word;
            rd_corr <= word[DATA_W-1:0];
            rd_syn <= syn;
            wait_n <= -1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/mceb_core_test.sv
/*
 Self-checking bench for mceb_core with the storage model on its far side.
 Assumes mceb_pkg, a 125 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mceb_core_test
    import mceb_pkg::*;
;
    localparam logic [DATA_W-1:0] DW = 60'h123_4567_89ab_cdef;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, st;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_valid;
    mceb_req_s req = '0;
    mceb_mem_s mem_out, m_seen;
    mceb_rsp_s rsp, r_seen;
    logic [DATA_W-1:0] rd_data, rd_corr;
    logic [SYN_W-1:0] rd_check, rd_syn, syn = 8'h00;
    logic [1:0] su_err, fail = 2'b00, lat = 2'b00;
    logic [5:0] exit_mode = 6'h00;
    int n_errors = 0, total_checks = 0, cycles = 0;

    mceb_core i_mceb_core (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req(req), .mem_out(mem_out),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_check(rd_check),
        .rd_syn(rd_syn), .rd_corr(rd_corr), .su_err_0(su_err[0]),
        .su_err_1(su_err[1]), .exit_mode(exit_mode), .rsp(rsp));
    mceb_store_model i_mceb_store_model (.clk(clk), .mem(mem_out),
        .lat(lat), .syn(syn), .fail(fail), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_check(rd_check), .rd_syn(rd_syn),
        .rd_corr(rd_corr), .su_err(su_err));

    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // Bus and request tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 st = reg_rdata;
    endtask
    task automatic ctrl(input logic cm, ig, input logic [1:0] ps, ac);
        wreg(MCEB_REG_CTRL, {20'h0, ac, ps, 6'h3f, ig, cm});
        wreg(MCEB_REG_STAT, 32'hffff_ffff);
    endtask
    // Bad parity on demand; waits a bounded time for the answer
    task automatic xfer(input logic [2:0] p, input mceb_ref_e k,
            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic ba, bd);
        int n;
        @(posedge clk);
        req <= '{1'b1, p, k, a, ~^a ^ ba, d, ~^d ^ bd};
        @(posedge clk);
        req.valid <= 1'b0;
        #1 m_seen = mem_out;
        n = 0;
        while (rsp.valid !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        r_seen = rsp;
        if (n == 12) chk(1'b0, 1'b1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rreg(MCEB_REG_CTRL);
        chk(st, CTRL_RESET);
        rreg(8'h20);
        chk(st, 32'h0);
        wreg(MCEB_REG_BKPT, 32'h0002_5a5a);
        rreg(MCEB_REG_BKPT);
        chk(st, 32'h0002_5a5a);
        $display("test regs done");
    endtask
    task automatic t_addr;
        ctrl(1'b0, 1'b0, 2'b00, 2'b00);
        exit_mode <= 6'h10;
        xfer(PORT_CPU0, REF_WRITE, 18'h00011, DW, 1'b1, 1'b0);
        chk(m_seen.wr, 1'b0);
        chk(r_seen.cpu_exit, 1'b1);
        rreg(MCEB_REG_STAT);
        chk(st & 32'h0703, 32'h0203);
        wreg(MCEB_REG_STAT, 32'hffff_ffff);
        xfer(PORT_PERI1, REF_READ, 18'h00012, DW, 1'b1, 1'b0);
        chk(r_seen.data, {DATA_W{1'b1}});
        chk(r_seen.cpu_exit, 1'b0);
        rreg(MCEB_REG_STAT);
        chk(st & 32'h0703, 32'h0103);
        exit_mode <= 6'h2f;
        xfer(PORT_CPU1, REF_WRITE, 18'h00013, DW, 1'b1, 1'b0);
        chk(r_seen.in_err, 1'b1);
        chk(r_seen.cpu_exit, 1'b0);
        $display("test address parity done");
    endtask
    task automatic t_data;
        ctrl(1'b0, 1'b0, 2'b00, 2'b00);
        xfer(PORT_PERI0, REF_WRITE, 18'h00020, DW, 1'b0, 1'b1);
        chk(r_seen.in_err, 1'b1);
        chk(r_seen.port, PORT_PERI0);
        rreg(MCEB_REG_STAT);
        chk(st & 32'h0707, 32'h0001);
        wreg(MCEB_REG_STAT, 32'hffff_ffff);
        xfer(PORT_XMEM, REF_WRITE, 18'h00021, DW, 1'b0, 1'b1);
        rreg(MCEB_REG_STAT);
        chk(st & 32'h0007, 32'h0005);
        xfer(PORT_CPU1, REF_WRITE, 18'h00022, DW, 1'b0, 1'b1);
        chk(r_seen.in_err, 1'b1);
        ctrl(1'b1, 1'b1, 2'b00, 2'b00);
        xfer(PORT_CPU0, REF_WRITE, 18'h00023, DW, 1'b0, 1'b1);
        chk(r_seen.in_err, 1'b0);
        xfer(PORT_PERI1, REF_WRITE, 18'h00024, DW, 1'b0, 1'b1);
        chk(r_seen.in_err, 1'b1);
        $display("test data parity done");
    endtask
    task automatic t_modes;
        logic [55:0] sv;
        logic [6:0] dv;
        sv = 56'h0f_03_7f_1f_07_01_00;
        dv = 7'b1100000;
        ctrl(1'b0, 1'b0, 2'b00, 2'b00);
        xfer(PORT_PERI0, REF_WRITE, 18'h00003, DW, 1'b0, 1'b0);
        chk(m_seen.wr, 1'b1);
        chk(m_seen.data, DW);
        chk(m_seen.addr_par, ~^18'h00003);
        chk(m_seen.check[2], ~^DW);
        lat <= 2'b10;
        xfer(PORT_PERI0, REF_READ, 18'h00003, DW, 1'b0, 1'b0);
        chk(r_seen.data, DW);
        chk(r_seen.data_par, ~^DW);
        ctrl(1'b1, 1'b0, 2'b00, 2'b00);
        lat <= 2'b00;
        xfer(PORT_PERI1, REF_WRITE, 18'h00005, DW, 1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            syn <= sv[8*i +: 8];
            xfer(PORT_PERI1, REF_READ, 18'h00005, DW, 1'b0, 1'b0);
            chk(r_seen.dbl_err, dv[i]);
            chk(r_seen.data, DW);
            chk(r_seen.data_par, ~^DW);
            rreg(MCEB_REG_STAT);
            chk(st[23:16], sv[8*i +: 8]);
        end
        syn <= 8'h00;
        for (int u = 1; u < 3; u++) begin
            wreg(MCEB_REG_STAT, 32'hffff_ffff);
            fail <= u[1:0];
            xfer(PORT_PERI0, REF_WRITE, 18'h00006, DW, 1'b0, 1'b0);
            @(posedge clk);
            rreg(MCEB_REG_STAT);
            fail <= 2'b00;
            chk(st[4:3], u[1:0]);
        end
        $display("test modes done");
    endtask
    task automatic t_bkpt;
        logic pok, aok;
        mceb_ref_e k;
        logic [2:0] p;
        wreg(MCEB_REG_BKPT, 32'h0000_1234);
        for (int s = 0; s < 16; s++) begin
            ctrl(1'b0, 1'b0, s[3:2], s[1:0]);
            for (int j = 0; j < 10; j++) begin
                k = mceb_ref_e'(j % 5);
                p = (j < 5) ? PORT_PERI0 : PORT_CPU1;
                pok = p[1] ? s[3] : s[2];
                case (s[1:0])
                    2'b00: aok = k inside {REF_READ, REF_IFETCH, REF_SWAP};
                    2'b01: aok = k inside {REF_WRITE, REF_SWAP, REF_RJUMP};
                    2'b10: aok = (k == REF_IFETCH);
                    default: aok = 1'b1;
                endcase
                xfer(p, k, 18'h01234, DW, 1'b0, 1'b0);
                chk(r_seen.bkpt, pok & aok);
            end
        end
        xfer(PORT_CPU1, REF_WRITE, 18'h01235, DW, 1'b0, 1'b0);
        chk(r_seen.bkpt, 1'b0);
        wreg(MCEB_REG_STAT, 32'hffff_ffff);
        xfer(PORT_CPU1, REF_WRITE, 18'h01234, DW, 1'b0, 1'b0);
        rreg(MCEB_REG_STAT);
        chk({st[13:12], st[5]}, 3'b111);
        $display("test breakpoint done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_addr();
        t_data();
        t_modes();
        t_bkpt();
        test_done();
    end
endmodule
`default_nettype wire
